// ===== core/ahl_history.sv
// Purpose: alarm history recorder with operating time stamps
// Assumes: alarm and command inputs come from ref_clk logic
// Notes: entry 0 is the latest, entry 9 the oldest
// Functional notes
// - the ten latest alarms are kept and the oldest falls out when full.
// - each entry holds the alarm number and the stamp taken at the alarm.
// - the stamp counts power on-time in 100 ms steps and is saved per alarm.
// - the on-time counter runs only while either power input is on and spans about thirteen years.
// - a repeat of a stored alarm number within one hour is not stored.
// - a read with no alarm at that place returns an empty indication.
// - alarm reset and main power loss never erase any entry.
// - only the history clear command and reset_n empty the history.
// - a command from a second source while one is busy is refused.
`timescale 1ns/1ns
`default_nettype none
`include "ahl_cfg.svh"
module ahl_history #(
   parameter int unsigned TICK_CYCLES = `AHL_CLK_HZ / 1000 * `AHL_TICK_MS
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic ctrl_power_on,
   input wire logic main_power_on,
   input wire logic alarm_valid,
   input wire ahl_pkg::ahl_code_t alarm_code,
   input wire logic panel_open,
   input wire logic panel_req,
   input wire logic panel_clear,
   input wire ahl_pkg::ahl_idx_t panel_index,
   input wire logic tool_open,
   input wire logic tool_req,
   input wire logic tool_clear,
   input wire ahl_pkg::ahl_idx_t tool_index,
   output logic rsp_valid,
   output logic rsp_source,
   output logic rsp_empty,
   output logic concurrent_use_refusal,
   output ahl_pkg::ahl_code_t rsp_code,
   output ahl_pkg::ahl_stamp_t rsp_stamp
);
   import ahl_pkg::*;

   localparam ahl_div_t DIV_LAST = ahl_div_t'(TICK_CYCLES - 1);
   localparam ahl_idx_t DEPTH = ahl_idx_t'(`AHL_DEPTH);

   ahl_state_s st;
   ahl_state_s next_st;
   logic tick;
   logic powered;
   logic dup;
   logic store_ok;
   logic clear_ok;
   logic refuse;
   logic acc_panel;
   logic acc_tool;
   logic req_clear;
   ahl_idx_t req_index;
   ahl_stamp_t age;

   always_comb begin
      next_st = st;
      // pin synchronisers, first stage read only by the second
      next_st.pwr_meta = {main_power_on, ctrl_power_on};
      next_st.pwr_sync = st.pwr_meta;
      powered = |st.pwr_sync;
      tick = (st.div == DIV_LAST);
      next_st.div = tick ? '0 : st.div + 24'h00_0001;
      if (tick && powered && st.ontime != 32'hffff_ffff) begin
         next_st.ontime = st.ontime + 32'h0000_0001;
      end
      acc_panel = panel_req && (st.owner != AHL_OWN_TOOL);
      acc_tool = tool_req && !acc_panel && (st.owner != AHL_OWN_PANEL);
      refuse = (panel_req && !acc_panel) || (tool_req && !acc_tool);
      if (acc_panel && panel_open) begin
         next_st.owner = AHL_OWN_PANEL;
      end else if (acc_tool && tool_open) begin
         next_st.owner = AHL_OWN_TOOL;
      end else if ((st.owner == AHL_OWN_PANEL && !panel_open) ||
                   (st.owner == AHL_OWN_TOOL && !tool_open)) begin
         next_st.owner = AHL_OWN_NONE;
      end
      req_clear = acc_panel ? panel_clear : tool_clear;
      req_index = acc_panel ? panel_index : tool_index;
      clear_ok = (acc_panel || acc_tool) && req_clear;
      if (clear_ok) begin
         next_st.count = `AHL_COUNT_RST;
      end
      dup = 1'b0;
      age = '0;
      for (int i = 0; i < `AHL_DEPTH; i++) begin
         age = st.ontime - st.stamp[i];
         if (ahl_idx_t'(i) < st.count && st.code[i] == alarm_code &&
             age <= `AHL_HOUR_TICKS && !clear_ok) begin
            dup = 1'b1;
         end
      end
      store_ok = alarm_valid && !dup;
      if (store_ok) begin
         for (int i = `AHL_DEPTH - 1; i > 0; i--) begin
            next_st.code[i] = st.code[i-1];
            next_st.stamp[i] = st.stamp[i-1];
         end
         next_st.code[0] = alarm_code;
         next_st.stamp[0] = st.ontime;
         if (clear_ok) begin
            next_st.count = 4'h1;
         end else if (st.count != DEPTH) begin
            next_st.count = st.count + 4'h1;
         end
      end
      next_st.rsp_valid = panel_req || tool_req;
      next_st.rsp_refused = refuse;
      next_st.rsp_source = acc_tool || (tool_req && !panel_req);
      next_st.rsp_empty = 1'b0;
      next_st.rsp_code = `AHL_CODE_RST;
      next_st.rsp_stamp = `AHL_STAMP_RST;
      if ((acc_panel || acc_tool) && !req_clear) begin
         if (req_index >= st.count) begin
            next_st.rsp_empty = 1'b1;
         end else begin
            next_st.rsp_code = st.code[req_index];
            next_st.rsp_stamp = st.stamp[req_index];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
         st.owner <= AHL_OWN_NONE;
      end else begin
         st <= next_st;
      end
   end

   assign rsp_valid = st.rsp_valid;
   assign rsp_source = st.rsp_source;
   assign rsp_empty = st.rsp_empty;
   assign concurrent_use_refusal = st.rsp_refused;
   assign rsp_code = st.rsp_code;
   assign rsp_stamp = st.rsp_stamp;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   a_depth_limit: assert property (st.count <= DEPTH)
      else $error("history holds more than ten entries");
   a_oldest_drop: assert property (
      store_ok && !clear_ok && st.count == DEPTH |=>
      st.count == DEPTH && st.code[9] == $past(st.code[8]))
      else $error("full history did not drop oldest");
   a_entry_pair: assert property (
      store_ok |=> st.code[0] == $past(alarm_code) &&
      st.code[1] == $past(st.code[0]))
      else $error("stored number wrong");
   a_stamp_take: assert property (
      store_ok |=> st.stamp[0] == $past(st.ontime))
      else $error("stamp not taken at alarm");
   a_tick_step: assert property (
      tick && powered && st.ontime != 32'hffff_ffff |=>
      st.ontime == $past(st.ontime) + 32'h0000_0001)
      else $error("on-time did not step");
   a_time_hold: assert property (
      !tick |=> st.ontime == $past(st.ontime))
      else $error("on-time moved without tick");
   a_hour_block: assert property (
      alarm_valid && dup |=> st.count == $past(st.count) &&
      st.code[0] == $past(st.code[0]))
      else $error("repeat within hour stored");
   a_empty_show: assert property (
      st.rsp_valid && st.rsp_empty |-> st.rsp_code == 12'h000 &&
      st.rsp_stamp == 32'h0000_0000 && !st.rsp_refused)
      else $error("empty read carries data");
   a_erase_cause: assert property (
      st.count < $past(st.count) |-> $past(clear_ok))
      else $error("history shrank without clear");
   a_busy_refuse: assert property (
      tool_req && st.owner == AHL_OWN_PANEL |=>
      concurrent_use_refusal && rsp_valid)
      else $error("second source not refused");
   a_answer_next: assert property (
      panel_req || tool_req |=> rsp_valid)
      else $error("request not answered");
   a_clear_empty: assert property (
      clear_ok && !store_ok |=> st.count == 4'h0)
      else $error("clear left entries");
   a_refused_noop: assert property (
      refuse && !acc_panel && !acc_tool && !alarm_valid |=>
      st.count == $past(st.count) && st.code == $past(st.code))
      else $error("refused command changed history");
   a_view_entry: assert property (
      acc_panel && !panel_clear && panel_index < st.count |=>
      rsp_code == $past(st.code[panel_index]) &&
      rsp_stamp == $past(st.stamp[panel_index]))
      else $error("view returned wrong entry");
   a_empty_view: assert property (
      acc_panel && !panel_clear && panel_index >= st.count |=> rsp_empty)
      else $error("missing entry not shown empty");
   a_idle_hold: assert property (
      !powered |=> st.ontime == $past(st.ontime))
      else $error("on-time moved while unpowered");
   a_history_keep: assert property (
      !store_ok |=> st.code == $past(st.code) && st.stamp == $past(st.stamp))
      else $error("history changed without alarm");
   a_source_tool: assert property (
      acc_tool |=> rsp_source)
      else $error("tool answer not marked as tool");

   c_full_wrap: cover property (store_ok && st.count == DEPTH);
   c_dup_seen: cover property (alarm_valid && dup);
   c_clear_done: cover property (clear_ok ##1 st.count == 4'h0);
   c_refused: cover property (concurrent_use_refusal);
   c_panel_busy: cover property (tool_req && st.owner == AHL_OWN_PANEL);
endmodule // ahl_history
`default_nettype wire

// ===== core/ahl_cfg.svh
// Purpose: constants of the alarm history recorder
// Assumes: 100 MHz reference clock
// Notes: definitions only
`ifndef AHL_CFG_SVH
`define AHL_CFG_SVH

// history depth in entries
`define AHL_DEPTH 10
// clock rate in hz and stamp step in ms
`define AHL_CLK_HZ 100000000
`define AHL_TICK_MS 100
// one hour in 100 ms steps
`define AHL_HOUR_TICKS 32'h0000_8ca0
// reset values
`define AHL_STAMP_RST 32'h0000_0000
`define AHL_CODE_RST 12'h000
`define AHL_COUNT_RST 4'h0

`endif

// ===== core/ahl_pkg.sv
// Purpose: types of the alarm history recorder
// Assumes: ahl_cfg.svh constants
// Notes: state of the recorder is one packed struct
`include "ahl_cfg.svh"
package ahl_pkg;
   typedef logic [11:0] ahl_code_t;
   typedef logic [31:0] ahl_stamp_t;
   typedef logic [3:0] ahl_idx_t;
   typedef logic [23:0] ahl_div_t;

   typedef enum logic [2:0] {
      AHL_OWN_NONE  = 3'b001,
      AHL_OWN_PANEL = 3'b010,
      AHL_OWN_TOOL  = 3'b100
   } ahl_owner_e;

   typedef struct packed {
      logic [1:0] pwr_meta;
      logic [1:0] pwr_sync;
      ahl_div_t div;
      ahl_stamp_t ontime;
      logic [`AHL_DEPTH-1:0][11:0] code;
      logic [`AHL_DEPTH-1:0][31:0] stamp;
      ahl_idx_t count;
      ahl_owner_e owner;
      logic rsp_valid;
      logic rsp_source;
      logic rsp_empty;
      logic rsp_refused;
      ahl_code_t rsp_code;
      ahl_stamp_t rsp_stamp;
   } ahl_state_s;
endpackage

// ===== tb/ahl_tool_model.sv
// Purpose: service tool side of the history command port
// Assumes: ahl_history answers one cycle after a request
// Notes: session stays open until close is called
`timescale 1ns/1ns
`default_nettype none
module ahl_tool_model (
   input wire logic ref_clk,
   output logic tool_open,
   output logic tool_req,
   output logic tool_clear,
   output ahl_pkg::ahl_idx_t tool_index
);
   import ahl_pkg::*;
   initial begin
      tool_open = 1'b0;
      tool_req = 1'b0;
      tool_clear = 1'b0;
      tool_index = 4'h0;
   end
   task automatic view(input ahl_idx_t i);
      @(posedge ref_clk);
      tool_open <= 1'b1;
      tool_req <= 1'b1;
      tool_index <= i;
      @(posedge ref_clk);
      tool_req <= 1'b0;
      tool_index <= ~i;
   endtask
   task automatic close();
      @(posedge ref_clk);
      tool_open <= 1'b0;
   endtask
endmodule // ahl_tool_model
`default_nettype wire

// ===== tb/ahl_history_tb.sv
// Purpose: self-checking bench of the alarm history recorder
// Assumes: stamp tick shortened to 10 cycles
// Notes: panel driven here, tool by the partner model
`timescale 1ns/1ns
`default_nettype none
module ahl_history_tb;
   import ahl_pkg::*;
   logic ref_clk = 1'b0, reset_n = 1'b0, cpw = 1'b1, mpw = 1'b1;
   logic av = 1'b0, p_open = 1'b0, p_req = 1'b0, p_clr = 1'b0;
   logic t_open, t_req, t_clr, rv, rs, re, rr;
   ahl_code_t ac = 12'h000, rc;
   ahl_idx_t p_idx = 4'h0, t_idx;
   ahl_stamp_t rst, s0;
   int n_fail = 0, cmp_count = 0, cyc = 0;
   always #5 ref_clk = ~ref_clk;
   ahl_tool_model u_tool (.ref_clk(ref_clk), .tool_open(t_open),
      .tool_req(t_req), .tool_clear(t_clr), .tool_index(t_idx));
   ahl_history #(.TICK_CYCLES(10)) u_dut (.ref_clk(ref_clk),
      .reset_n(reset_n), .ctrl_power_on(cpw), .main_power_on(mpw),
      .alarm_valid(av), .alarm_code(ac), .panel_open(p_open),
      .panel_req(p_req), .panel_clear(p_clr), .panel_index(p_idx),
      .tool_open(t_open), .tool_req(t_req), .tool_clear(t_clr),
      .tool_index(t_idx), .rsp_valid(rv), .rsp_source(rs),
      .rsp_empty(re), .concurrent_use_refusal(rr), .rsp_code(rc),
      .rsp_stamp(rst));
   task automatic chk(input string n, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wait_rsp();
      #1;
      chk("rsp_valid", 1, rv);
   endtask
   task automatic preq(input logic c, input ahl_idx_t i);
      @(posedge ref_clk);
      p_open <= 1'b1;
      p_req <= 1'b1;
      p_clr <= c;
      p_idx <= i;
      @(posedge ref_clk);
      p_open <= 1'b0;
      p_req <= 1'b0;
      p_idx <= ~i;
      wait_rsp();
   endtask
   task automatic pview(input ahl_idx_t i, input ahl_code_t c,
         input logic e);
      preq(1'b0, i);
      chk("rsp_empty", e, re);
      chk("rsp_code", c, rc);
      if (e) begin
         chk("empty stamp", 0, rst);
      end
   endtask
   task automatic t_empty();
      pview(4'h0, 12'h000, 1'b1);
      $display("test empty done");
   endtask
   task automatic alarm(input ahl_code_t c);
      @(posedge ref_clk);
      av <= 1'b1;
      ac <= c;
      @(posedge ref_clk);
      av <= 1'b0;
   endtask
   task automatic t_stamp();
      alarm(12'h101);
      repeat (98) @(posedge ref_clk);
      alarm(12'h202);
      pview(4'h1, 12'h101, 1'b0);
      s0 = rst;
      pview(4'h0, 12'h202, 1'b0);
      chk("stamp step", s0 + 32'd10, rst);
      $display("test stamp done");
   endtask
   task automatic t_fill();
      preq(1'b1, 4'h0);
      chk("clear code", 0, rc);
      pview(4'h0, 12'h000, 1'b1);
      for (int k = 1; k <= 11; k++) begin
         alarm(12'(k));
      end
      pview(4'h0, 12'h00b, 1'b0);
      pview(4'h9, 12'h002, 1'b0);
      pview(4'ha, 12'h000, 1'b1);
      alarm(12'h00b);
      pview(4'h1, 12'h00a, 1'b0);
      @(posedge ref_clk);
      mpw <= 1'b0;
      repeat (20) @(posedge ref_clk);
      pview(4'h0, 12'h00b, 1'b0);
      @(posedge ref_clk);
      mpw <= 1'b1;
      $display("test fill done");
   endtask
   task automatic t_busy();
      @(posedge ref_clk);
      p_open <= 1'b1;
      p_req <= 1'b1;
      p_clr <= 1'b0;
      p_idx <= 4'h0;
      @(posedge ref_clk);
      p_req <= 1'b0;
      wait_rsp();
      chk("panel code", 12'h00b, rc);
      u_tool.view(4'h0);
      wait_rsp();
      chk("busy refusal", 1, rr);
      chk("busy source", 1, rs);
      chk("busy code", 0, rc);
      @(posedge ref_clk);
      p_open <= 1'b0;
      $display("test busy done");
   endtask
   task automatic t_refuse();
      u_tool.view(4'h0);
      wait_rsp();
      chk("tool source", 1, rs);
      chk("tool code", 12'h00b, rc);
      preq(1'b1, 4'h0);
      chk("refusal", 1, rr);
      chk("refused source", 0, rs);
      u_tool.close();
      pview(4'h0, 12'h00b, 1'b0);
      chk("no refusal", 0, rr);
      $display("test refuse done");
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 5000) begin
         n_fail++;
         wrap_up();
      end
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_empty();
      t_stamp();
      t_fill();
      t_busy();
      t_refuse();
      wrap_up();
   end
endmodule // ahl_history_tb
`default_nettype wire
